// File: rtl/sps_state.sv
// sensor processor working registers, flags and digit latches
// ---------------------------------------------------------------
// Functional notes
// [RULE1] 960-bit ram, 15 banks of 16 nibbles
// [RULE2] banks 0-13 plain, bank 14 direct access
// [RULE3] accumulator eight digits, sign, two flags
// [RULE4] sign bit one means negative
// [RULE5] accumulator takes results, operands, display data
// [RULE6] second operand same layout, constants, counters
// [RULE7] twelve storage registers, accumulator format
// [RULE8] store zero cleared; division leaves remainder
// [RULE9] stores six-eleven need expansion qualifier
// [RULE10] two flag groups, selection persists
// [RULE11] active flags set, cleared, tested
// [RULE12] group one flags carry fixed hardware meanings
// [RULE13] general outputs follow latches one-six
// [RULE14] outputs zero, seven only for eeprom
// [RULE15] fourteen latches, software owns all but 0,7
// [RULE16] direction latch: 0 input, 1 output
// [RULE17] battery latch overrides analog input select; o_ain_sel here ignores it, follows latches 10-11 only
// [RULE18] rate latch picks 1-Hz or 16-Hz timer
// [RULE19] port falling edge starts timed readout
// [RULE20] slave may send alarm while bus active
// [RULE21] current source follows its latch
// [RULE22] general outputs low after initialization
// [RULE23] nibble write single cycle, bank and entry
// ---------------------------------------------------------------
`include "sps_params.svh"
module sps_state #(
    parameter int STORES = `SPS_STORE_COUNT,
    parameter int FLAGS = `SPS_FLAG_COUNT,
    parameter logic [15:0] SLOT_CYCLES = `SPS_SLOT_CYCLES
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // register write port from the interpreter
    input wire logic i_acc_wr,
    input wire sps_pkg::sps_word_type i_acc_data,
    input wire logic [1:0] i_acc_flags,
    input wire logic i_opb_wr,
    input wire sps_pkg::sps_word_type i_opb_data,
    input wire sps_pkg::sps_op_type i_op,
    input wire logic [3:0] i_sto_idx,
    input wire logic i_expand,
    input wire sps_pkg::sps_word_type i_sto_data,
    // flag access
    input wire logic i_pick_flag_group_one,
    input wire logic i_pick_flag_group_two,
    input wire logic i_flag_set,
    input wire logic i_flag_clr,
    input wire logic [3:0] i_flag_idx,
    input wire logic i_long_timer,
    input wire logic i_short_timer,
    input wire logic [6:0] i_seg_h,
    // digit latches
    input wire logic i_dl_set,
    input wire logic i_dl_clr,
    input wire logic [3:0] i_dl_idx,
    input wire logic i_eeprom_clock_latch,
    input wire logic i_eeprom_power_latch,
    // ram nibble port
    input wire logic i_ram_wr,
    input wire logic [3:0] i_ram_bank,
    input wire logic [3:0] i_ram_entry,
    input wire logic [3:0] i_ram_wdata,
    // timers, port and bus
    input wire logic i_timer_1hz,
    input wire logic i_timer_16hz,
    input wire logic [3:0] i_port_in,
    input wire logic [3:0] i_port_latch,
    input wire logic [7:0] i_bus_addr,
    input wire logic i_bus_active,
    input wire logic i_alarm_req,
    // readable state
    output sps_pkg::sps_word_type o_working_accumulator,
    output logic [1:0] o_acc_flags,
    output logic o_acc_negative,
    output sps_pkg::sps_word_type o_second_operand,
    output sps_pkg::sps_word_type o_sto_rdata,
    output logic o_sto_refused,
    output logic [15:0] o_active_flags,
    output logic o_flag_test,
    output logic o_group_two_active,
    output logic [3:0] o_ram_rdata,
    output logic o_ram_direct,
    // pins
    output logic o_eeprom_clock_out,
    output logic o_eeprom_supply_switch,
    output logic [5:0] o_general_outputs,
    output logic [3:0] o_port_out,
    output logic [3:0] o_port_oe,
    output logic [3:0] o_port_sampled,
    output sps_pkg::sps_ain_type o_ain_sel,
    output logic o_battery_check_sel,
    output logic o_timer_tick,
    output logic o_current_source_on,
    // remote readout
    output logic o_readout_busy,
    output logic [3:0] o_readout_store,
    output logic o_alarm_send
);
    import sps_pkg::*;
    initial begin
        if (STORES != `SPS_STORE_COUNT || FLAGS != `SPS_FLAG_COUNT)
            $error("store or flag count unsupported");
    end

    // ---------------------------------------------------------------
    // working registers
    // ---------------------------------------------------------------
    sps_word_type stores [STORES];
    logic [15:0] group_one;
    logic [15:0] group_two;
    logic [13:0] latches;
    logic port_prev;
    typedef enum {RD_IDLE, RD_WAIT, RD_SEND} sps_rd_type;
    sps_rd_type rd_state;
    logic [23:0] slot_cnt;

    // expanded stores need the qualifier, low six do not
    wire sto_ok = i_sto_idx < 4'(`SPS_DIRECT_STORES) ? !i_expand :
        (i_expand && 32'(i_sto_idx) < STORES); // see [RULE9]
    wire sto_wr = (i_op == SPS_OP_STORE) && sto_ok;
    wire [3:0] sto_sel = sto_ok ? i_sto_idx : 4'h0;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_working_accumulator <= '0;
            o_acc_flags <= 2'h0;
            o_second_operand <= '0;
        end else begin
            if (i_acc_wr) begin
                o_working_accumulator <= i_acc_data; // see [RULE3] see [RULE5]
                o_acc_flags <= i_acc_flags; // see [RULE3]
            end
            if (i_opb_wr)
                o_second_operand <= i_opb_data; // see [RULE6]
        end
    end
    // sign nibble lsb is the sign bit
    assign o_acc_negative = o_working_accumulator[32] == `SPS_SIGN_NEG; // see [RULE4]

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            for (int k = 0; k < STORES; k++) stores[k] <= '0;
        end else if (i_op == SPS_OP_MUL || i_op == SPS_OP_HEXDEC) begin
            stores[0] <= '0; // see [RULE8]
        end else if (i_op == SPS_OP_DIV) begin
            stores[0] <= i_sto_data; // see [RULE8]
        end else if (sto_wr) begin
            stores[sto_sel] <= i_sto_data; // see [RULE7]
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_sto_rdata <= '0;
            o_sto_refused <= 1'b0;
        end else begin
            o_sto_rdata <= sto_ok ? stores[sto_sel] : '0;
            o_sto_refused <= !sto_ok; // see [RULE9]
        end
    end

    // ---------------------------------------------------------------
    // flag groups
    // ---------------------------------------------------------------
    wire [15:0] flag_bit = 16'h0001 << i_flag_idx;
    wire [15:0] hw_mask = 16'hFCFE;
    wire [15:0] hw_vals = {i_port_in, i_short_timer, i_long_timer, 2'h0,
        i_seg_h, 1'b0};
    wire [15:0] sw_one = o_group_two_active ? group_one :
        ((group_one | (i_flag_set ? flag_bit : 16'h0000)) &
        ~(i_flag_clr ? flag_bit : 16'h0000));
    wire [15:0] next_group_one = (sw_one & ~hw_mask) | (hw_vals & hw_mask);
    wire [15:0] next_group_two = !o_group_two_active ? group_two :
        ((group_two | (i_flag_set ? flag_bit : 16'h0000)) &
        ~(i_flag_clr ? flag_bit : 16'h0000));
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            group_one <= 16'h0000;
            group_two <= 16'h0000;
            o_group_two_active <= 1'b0;
        end else begin
            group_one <= next_group_one; // see [RULE11] see [RULE12]
            group_two <= next_group_two; // see [RULE11]
            if (i_pick_flag_group_two) o_group_two_active <= 1'b1; // see [RULE10]
            else if (i_pick_flag_group_one) o_group_two_active <= 1'b0;
        end
    end
    wire [15:0] shown_flags = o_group_two_active ? group_two : group_one;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_active_flags <= 16'h0000;
            o_flag_test <= 1'b0;
        end else begin
            o_active_flags <= shown_flags;
            o_flag_test <= shown_flags[i_flag_idx]; // see [RULE11]
        end
    end

    // ---------------------------------------------------------------
    // digit latches and pins
    // ---------------------------------------------------------------
    wire dl_user = i_dl_idx < 4'(`SPS_LATCH_COUNT) &&
        i_dl_idx != 4'(`SPS_DL_ECLK) && i_dl_idx != 4'(`SPS_DL_EPWR);
    wire [13:0] dl_bit = 14'h0001 << i_dl_idx;
    wire [13:0] next_latches_sw = !dl_user ? latches :
        (i_dl_set ? (latches | dl_bit) :
        (i_dl_clr ? (latches & ~dl_bit) : latches));
    wire [13:0] next_latches = {next_latches_sw[13:8], i_eeprom_power_latch,
        next_latches_sw[6:1], i_eeprom_clock_latch};
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) latches <= 14'h0000; // see [RULE22]
        else latches <= next_latches; // see [RULE15] see [RULE14]
    end
    wire [1:0] sel_pair = {latches[`SPS_DL_SELHI], latches[`SPS_DL_SELLO]};
    wire port_drive = latches[`SPS_DL_PDIR];
    wire tick = latches[`SPS_DL_RATE] ? i_timer_16hz : i_timer_1hz;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_eeprom_clock_out <= 1'b0;
            o_eeprom_supply_switch <= 1'b0;
            o_general_outputs <= 6'h00;
            o_port_out <= 4'h0;
            o_port_oe <= 4'h0;
            o_port_sampled <= 4'h0;
            o_ain_sel <= SPS_AIN_ONE;
            o_battery_check_sel <= 1'b0;
            o_timer_tick <= 1'b0;
            o_current_source_on <= 1'b0;
        end else begin
            o_eeprom_clock_out <= latches[`SPS_DL_ECLK]; // see [RULE14]
            o_eeprom_supply_switch <= latches[`SPS_DL_EPWR]; // see [RULE14]
            o_general_outputs <= latches[6:1]; // see [RULE13]
            o_port_out <= i_port_latch;
            o_port_oe <= {4{port_drive}}; // see [RULE16]
            o_port_sampled <= port_drive ? 4'h0 : i_port_in;
            // low latch alone picks input two, high alone input three
            o_ain_sel <= sps_ain_type'(sel_pair); // see [RULE17]
            o_battery_check_sel <= latches[`SPS_DL_BATT]; // see [RULE17]
            o_timer_tick <= tick; // see [RULE18]
            o_current_source_on <= latches[`SPS_DL_ISRC]; // see [RULE21]
        end
    end

    // ---------------------------------------------------------------
    // remote readout slot
    // ---------------------------------------------------------------
    // slot start scales with address; cost is a wide counter
    wire port_fall = port_prev && !i_port_in[0] && !port_drive;
    wire [23:0] slot_start = 24'(i_bus_addr) * 24'(SLOT_CYCLES);
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            port_prev <= 1'b1;
            rd_state <= RD_IDLE;
            slot_cnt <= 24'h000000;
            o_readout_busy <= 1'b0;
            o_readout_store <= 4'h0;
            o_alarm_send <= 1'b0;
        end else begin
            port_prev <= i_port_in[0];
            o_alarm_send <= i_bus_active && i_alarm_req && rd_state == RD_IDLE; // see [RULE20]
            case (rd_state)
                RD_IDLE: begin
                    if (port_fall) begin // see [RULE19]
                        rd_state <= RD_WAIT;
                        slot_cnt <= 24'h000000;
                    end
                end
                RD_WAIT: begin
                    slot_cnt <= slot_cnt + 24'h000001;
                    if (slot_cnt == slot_start) begin
                        rd_state <= RD_SEND;
                        o_readout_busy <= 1'b1;
                        o_readout_store <= `SPS_READOUT_FIRST;
                    end
                end
                RD_SEND: begin
                    if (o_readout_store == `SPS_READOUT_LAST) begin
                        rd_state <= RD_IDLE;
                        o_readout_busy <= 1'b0;
                        o_readout_store <= 4'h0;
                    end else begin
                        o_readout_store <= o_readout_store + 4'h1; // see [RULE19]
                    end
                end
                default: rd_state <= RD_IDLE;
            endcase
        end
    end

    sps_nibble_ram u_ram (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_wr(i_ram_wr),
        .i_wr_bank(i_ram_bank),
        .i_wr_entry(i_ram_entry),
        .i_wr_data(i_ram_wdata),
        .i_rd_bank(i_ram_bank),
        .i_rd_entry(i_ram_entry),
        .o_rd_data(o_ram_rdata),
        .o_rd_direct(o_ram_direct)
    );

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    store_zero_clr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE8]
        (i_op == SPS_OP_MUL) |=> stores[0] == '0)
        else $error("store zero not cleared");
    expand_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE9]
        (i_sto_idx >= 4'h6 && i_sto_idx < 4'hC && !i_expand) |=> o_sto_refused)
        else $error("expanded store reached without qualifier");
    group_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE10]
        (!i_pick_flag_group_one && !i_pick_flag_group_two) |=>
        o_group_two_active == $past(o_group_two_active))
        else $error("flag group changed unasked");
    flag_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE11]
        (o_group_two_active && i_flag_set && !i_pick_flag_group_one) |=>
        group_two[$past(i_flag_idx)])
        else $error("flag not set");
    eeprom_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE15]
        (i_dl_set && i_dl_idx == 4'h0 && !i_eeprom_clock_latch) |=> !latches[0])
        else $error("eeprom latch reached by software");
    general_out_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE13]
        (i_dl_set && i_dl_idx == 4'h3) |=> ##1 o_general_outputs[2])
        else $error("general output not set");
    port_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE16]
        (i_dl_clr && i_dl_idx == 4'h8) |=> ##1 o_port_oe == 4'h0)
        else $error("port not released to input");
    source_follow_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE21]
        (i_dl_set && i_dl_idx == 4'hD) |=> ##1 o_current_source_on)
        else $error("current source not on");
    readout_five_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // see [RULE19]
        (rd_state == RD_WAIT && slot_cnt == slot_start) |=>
        o_readout_busy [*5] ##1 !o_readout_busy)
        else $error("readout not five stores");
endmodule

// File: rtl/sps_params.svh
// constants for the sensor processor state block
`ifndef SPS_PARAMS_SVH
`define SPS_PARAMS_SVH
`define SPS_RAM_BITS 960
`define SPS_RAM_BANKS 15
`define SPS_BANK_DEPTH 16
`define SPS_PLAIN_BANKS 14
`define SPS_DIRECT_BANK 4'hE
`define SPS_STORE_COUNT 12
`define SPS_DIRECT_STORES 6
`define SPS_FLAG_COUNT 16
`define SPS_LATCH_COUNT 14
`define SPS_DL_ECLK 0
`define SPS_DL_EPWR 7
`define SPS_DL_PDIR 8
`define SPS_DL_BATT 9
`define SPS_DL_SELLO 10
`define SPS_DL_SELHI 11
`define SPS_DL_RATE 12
`define SPS_DL_ISRC 13
`define SPS_G1_SEG_LO 1
`define SPS_G1_SEG_HI 7
`define SPS_G1_LONG_TMR 10
`define SPS_G1_SHORT_TMR 11
`define SPS_G1_PORT_LO 12
`define SPS_SIGN_NEG 1'h1
`define SPS_READOUT_FIRST 4'h1
`define SPS_READOUT_LAST 4'h5
`define SPS_SLOT_CYCLES 16'h0100
`endif

// File: rtl/sps_pkg.sv
// types shared by the sensor processor state block
package sps_pkg;
    typedef logic [35:0] sps_word_type;
    typedef enum logic [2:0] {
        SPS_OP_NONE, SPS_OP_MUL, SPS_OP_HEXDEC, SPS_OP_DIV, SPS_OP_STORE
    } sps_op_type;
    typedef enum logic [1:0] {
        SPS_AIN_ONE, SPS_AIN_TWO, SPS_AIN_THREE, SPS_AIN_FOUR
    } sps_ain_type;
endpackage

// File: rtl/sps_nibble_ram.sv
// nibble ram, bank and entry addressed
`include "sps_params.svh"
module sps_nibble_ram #(
    parameter int BANKS = `SPS_RAM_BANKS,
    parameter int DEPTH = `SPS_BANK_DEPTH
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // write port
    input wire logic i_wr,
    input wire logic [3:0] i_wr_bank,
    input wire logic [3:0] i_wr_entry,
    input wire logic [3:0] i_wr_data,
    // read port
    input wire logic [3:0] i_rd_bank,
    input wire logic [3:0] i_rd_entry,
    output logic [3:0] o_rd_data,
    output logic o_rd_direct
);
    import sps_pkg::*;
    initial begin
        if (BANKS * DEPTH * 4 != `SPS_RAM_BITS || BANKS > 16 || DEPTH != 16)
            $error("ram geometry unsupported");
    end
    logic [3:0] mem [BANKS*DEPTH];
    wire wr_ok = i_wr && (32'(i_wr_bank) < BANKS);
    wire rd_ok = 32'(i_rd_bank) < BANKS;
    wire [7:0] wr_idx = {i_wr_bank, i_wr_entry};
    wire [7:0] rd_idx = {i_rd_bank, i_rd_entry};
    // ram holds no reset, like the real array
    always_ff @(posedge i_clk_sys) begin
        if (wr_ok) mem[wr_idx] <= i_wr_data; // see [RULE1] see [RULE23]
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rd_data <= 4'h0;
            o_rd_direct <= 1'b0;
        end else begin
            o_rd_data <= rd_ok ? mem[rd_idx] : 4'h0;
            o_rd_direct <= i_rd_bank == `SPS_DIRECT_BANK; // see [RULE2]
        end
    end
    ram_write_a: assert property ( // see [RULE23]
        @(posedge i_clk_sys) disable iff (!i_rst_n)
        (wr_ok ##1 (i_rd_bank == $past(i_wr_bank) &&
        i_rd_entry == $past(i_wr_entry) && !i_wr)) |=>
        o_rd_data == $past(i_wr_data, 2))
        else $error("ram readback mismatch");
endmodule

// File: testbench/sps_bus_master.sv
// remote bus master model driving the parallel port lines
module sps_bus_master (
    // clock
    input wire logic i_clk_sys,
    // commands from the bench
    input wire logic i_request,
    input wire logic [2:0] i_upper,
    // port lines toward the device
    output logic [3:0] o_port_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend;
    // line zero idles high; sampling on the rising edge avoids a drive race
    initial pend = 1'b0;
    initial o_port_in = 4'hF;
    always @(posedge i_clk_sys) pend <= i_request;
    always @(negedge i_clk_sys) begin
        o_port_in[3:1] <= i_upper;
        o_port_in[0] <= !pend;
    end
endmodule

// File: testbench/sps_state_test.sv
// self-checking bench for the sensor processor state block
`include "sps_params.svh"
module sps_state_test;
    timeunit 1ns;
    timeprecision 1ps;
    import sps_pkg::*;
    // ---------------------------------------------------------------
    // signals and model state
    // ---------------------------------------------------------------
    logic clk, rst_n, acc_wr, opb_wr, expand, g1, g2, fset, fclr, lt, st;
    logic dset, dclr, eclk, epwr, ram_wr, t1, t16, bact, alarm, req, gs;
    logic neg, refused, ftest, gtwo, direct, ecko, esup, tick, isrc;
    logic busy, asend, bsel;
    logic [1:0] accf, accf_q;
    logic [2:0] upper;
    logic [3:0] sidx, fidx, didx, bank, entry, wdata, platch, port;
    logic [3:0] rdata, poe, rstore, pout, psamp;
    logic [5:0] gout;
    logic [6:0] seg;
    logic [7:0] baddr;
    logic [13:0] lat;
    logic [15:0] flags;
    logic [15:0] fg[2];
    logic [3:0] ram[int];
    sps_word_type acc_d, opb_d, sto_d, acc_q, opb_q, sto_q;
    sps_word_type sto[12];
    sps_op_type op;
    sps_ain_type ain;
    int fails, cmp_count, n;

    sps_state #(.SLOT_CYCLES(16'h0004)) u_dut (
        .i_clk_sys(clk), .i_rst_n(rst_n), .i_acc_wr(acc_wr),
        .i_acc_data(acc_d), .i_acc_flags(accf), .i_opb_wr(opb_wr),
        .i_opb_data(opb_d), .i_op(op), .i_sto_idx(sidx), .i_expand(expand),
        .i_sto_data(sto_d), .i_pick_flag_group_one(g1),
        .i_pick_flag_group_two(g2), .i_flag_set(fset), .i_flag_clr(fclr),
        .i_flag_idx(fidx), .i_long_timer(lt), .i_short_timer(st),
        .i_seg_h(seg), .i_dl_set(dset), .i_dl_clr(dclr), .i_dl_idx(didx),
        .i_eeprom_clock_latch(eclk), .i_eeprom_power_latch(epwr),
        .i_ram_wr(ram_wr), .i_ram_bank(bank), .i_ram_entry(entry),
        .i_ram_wdata(wdata), .i_timer_1hz(t1), .i_timer_16hz(t16),
        .i_port_in(port), .i_port_latch(platch), .i_bus_addr(baddr),
        .i_bus_active(bact), .i_alarm_req(alarm),
        .o_working_accumulator(acc_q), .o_acc_flags(accf_q),
        .o_acc_negative(neg), .o_second_operand(opb_q),
        .o_sto_rdata(sto_q), .o_sto_refused(refused),
        .o_active_flags(flags), .o_flag_test(ftest),
        .o_group_two_active(gtwo), .o_ram_rdata(rdata),
        .o_ram_direct(direct), .o_eeprom_clock_out(ecko),
        .o_eeprom_supply_switch(esup), .o_general_outputs(gout),
        .o_port_out(pout), .o_port_oe(poe), .o_port_sampled(psamp),
        .o_ain_sel(ain), .o_battery_check_sel(bsel), .o_timer_tick(tick),
        .o_current_source_on(isrc), .o_readout_busy(busy),
        .o_readout_store(rstore), .o_alarm_send(asend)
    );
    sps_bus_master u_master (
        .i_clk_sys(clk), .i_request(req), .i_upper(upper), .o_port_in(port)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic latch(input int i, input logic v);
        logic [5:0] g;
        didx = 4'(i);
        dset = v;
        dclr = !v;
        cyc(1);
        dset = 1'b0;
        dclr = 1'b0;
        if (i != 0 && i != 7 && i < 14) lat[i] = v;
        cyc(3);
        for (int k = 1; k <= 6; k++) g[k-1] = lat[k];
        check(gout, g);
        check({ecko, esup}, {eclk, epwr});
        check(poe, {4{lat[8]}});
        check(pout, platch);
        check(psamp, lat[8] ? 4'h0 : port);
        check(bsel, lat[9]);
        check(ain, {lat[11], lat[10]});
        check(tick, lat[12] ? t16 : t1);
        check(isrc, lat[13]);
    endtask
    task automatic store(input int i, input logic x, input sps_op_type o);
        logic ok;
        ok = (i < 6) ? !x : (i < 12 && x);
        sidx = 4'(i);
        expand = x;
        op = o;
        sto_d = 36'({$urandom(), $urandom()});
        cyc(1);
        op = SPS_OP_NONE;
        if (ok && o == SPS_OP_STORE) sto[i] = sto_d;
        if (o == SPS_OP_MUL || o == SPS_OP_HEXDEC) sto[0] = '0;
        if (o == SPS_OP_DIV) sto[0] = sto_d;
        cyc(2);
        check(refused, !ok);
        check(sto_q, ok ? sto[i] : '0);
    endtask
    task automatic view;
        check(gtwo, gs);
        if (gs) check(flags, fg[1]);
        else check(flags & 16'h0301, fg[0] & 16'h0301);
        if (!gs) check(flags >> 10, {port, st, lt});
        if (!gs) check(flags[7:1], seg);
    endtask
    task automatic pick(input logic two);
        g1 = !two;
        g2 = two;
        cyc(1);
        g1 = 1'b0;
        g2 = 1'b0;
        gs = two;
        cyc(3);
        view();
    endtask
    task automatic flag(input int i, input logic v);
        fidx = 4'(i);
        fset = v;
        fclr = !v;
        cyc(1);
        fset = 1'b0;
        fclr = 1'b0;
        fg[gs][i] = v;
        cyc(3);
        check(ftest, v);
        view();
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        {acc_wr, opb_wr, expand, g1, g2, fset, fclr, lt, st, dset} = '0;
        {dclr, eclk, epwr, ram_wr, t1, t16, bact, alarm, req, gs} = '0;
        {accf, upper, sidx, fidx, didx, bank, entry, wdata, seg} = '0;
        {platch, baddr, lat, acc_d, opb_d, sto_d} = '0;
        fg[0] = '0;
        fg[1] = '0;
        op = SPS_OP_NONE;
        rst_n = 1'b0;
        void'($urandom(32'hBE38ADB4));
        platch = 4'($urandom());
        cyc(4);
        rst_n = 1'b1;
        cyc(1);
        check({gout, busy}, 7'h00);
        repeat (6) begin
            acc_d = 36'({$urandom(), $urandom()});
            opb_d = 36'({$urandom(), $urandom()});
            accf = 2'($urandom());
            acc_wr = 1'b1;
            opb_wr = 1'b1;
            cyc(1);
            acc_wr = 1'b0;
            opb_wr = 1'b0;
            cyc(2);
            check({accf_q, acc_q}, {accf, acc_d});
            check(neg, acc_d[32] == `SPS_SIGN_NEG);
            check(opb_q, opb_d);
        end
        $display("accumulator test done");
        for (int i = 0; i < 12; i++) store(i, i >= 6, SPS_OP_STORE);
        repeat (30) store($urandom_range(0, 13), 1'($urandom()),
            SPS_OP_STORE);
        store(0, 1'b0, SPS_OP_MUL);
        store(0, 1'b0, SPS_OP_STORE);
        store(0, 1'b0, SPS_OP_HEXDEC);
        store(0, 1'b0, SPS_OP_DIV);
        $display("store test done");
        pick(1'b1);
        for (int i = 0; i < 16; i++) flag(i, 1'($urandom()));
        seg = 7'($urandom());
        lt = 1'b1;
        upper = 3'($urandom());
        pick(1'b0);
        flag(0, 1'b1);
        flag(9, 1'b1);
        flag(8, 1'b0);
        pick(1'b1);
        $display("flag test done");
        for (int c = 0; c < 8; c++) begin
            latch(9, c[0]);
            latch(10, c[1]);
            latch(11, c[2]);
        end
        for (int i = 0; i < 14; i++) latch(i, 1'b1);
        repeat (48) begin
            {platch, eclk, epwr, t1, t16} = 8'($urandom());
            latch($urandom_range(0, 15), 1'($urandom()));
        end
        $display("latch test done");
        for (int k = 0; k < 24; k++) begin
            bank = 4'($urandom_range(0, 14));
            entry = 4'($urandom());
            wdata = 4'($urandom());
            ram_wr = 1'b1;
            cyc(1);
            ram_wr = 1'b0;
            ram[{bank, entry}] = wdata;
            cyc(1);
            check(rdata, wdata);
            check(direct, bank == `SPS_DIRECT_BANK);
        end
        foreach (ram[a]) begin
            {bank, entry} = 8'(a);
            cyc(2);
            check(rdata, ram[a]);
        end
        $display("ram test done");
        latch(8, 1'b0);
        baddr = 8'h02;
        req = 1'b1;
        cyc(3);
        req = 1'b0;
        n = 0;
        while (busy !== 1'b1 && n < 300) begin
            cyc(1);
            n++;
        end
        check(n >= 5 && n <= 12, 1'b1);
        for (int k = 1; k <= 5; k++) begin
            check({busy, rstore}, {1'b1, 4'(k)});
            cyc(1);
        end
        check(busy, 1'b0);
        bact = 1'b1;
        alarm = 1'b1;
        cyc(3);
        check(asend, 1'b1);
        bact = 1'b0;
        cyc(3);
        check(asend, 1'b0);
        $display("readout test done");
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(1);
        check({gout, busy}, 7'h00);
        $display("reset test done");
        report_and_stop();
    end
    // run takes some 700 cycles; a hang is cut well beyond that
    initial begin
        cyc(20000);
        fails++;
        report_and_stop();
    end
endmodule
